// [common/vtrf_defines.vh]
// Constants for the vicinity tag request filter.
`ifndef VTRF_DEFINES_VH
`define VTRF_DEFINES_VH
// Register byte offsets.
`define VTRF_REG_CTRL      8'h00
`define VTRF_REG_STATUS    8'h04
`define VTRF_REG_LASTREQ   8'h08
`define VTRF_REG_TXDATA    8'h0C
`define VTRF_REG_TXLEN     8'h10
// Field positions.
`define VTRF_CTRL_EN_BIT   0
`define VTRF_ST_STATE_LSB  0
`define VTRF_ST_BUSY_BIT   4
`define VTRF_ST_DROP_LSB   8
`define VTRF_LR_FLAGS_LSB  0
`define VTRF_LR_CMD_LSB    8
`define VTRF_LR_BYTES_LSB  16
`define VTRF_LR_NEW_BIT    24
`define VTRF_LR_ERR_BIT    25
// Reset values.
`define VTRF_CTRL_RST      1'b1
`define VTRF_TXLEN_RST     3'h0
`define VTRF_TXDATA_RST    32'h0000_0000
// Tag states.
`define VTRF_S_OFF         2'h0
`define VTRF_S_READY       2'h1
`define VTRF_S_QUIET       2'h2
`define VTRF_S_SEL         2'h3
// Request flag bit indexes (flag bit n sits at index n-1).
`define VTRF_F_INV         2
`define VTRF_F_SEL         4
`define VTRF_F_ADR         5
// Command codes that move the state machine.
`define VTRF_CMD_QUIET     8'h02
`define VTRF_CMD_SELECT    8'h25
`define VTRF_CMD_RESET     8'h26
// Response values.
`define VTRF_RSP_OK        8'h00
`define VTRF_RSP_ERRFLAG   8'h01
`define VTRF_ERR_CODE      8'h03
`define VTRF_TXLEN_MAX     3'h4
// Frame sizes in bytes.
`define VTRF_MIN_BYTES     8'h04
`define VTRF_MIN_ADDR_BYTES 8'h0C
`define VTRF_UID_FIRST     8'h02
`define VTRF_UID_LAST      8'h09
// CRC-16, reflected form.
`define VTRF_CRC_PRESET    16'hFFFF
`define VTRF_CRC_POLY      16'h8408
`define VTRF_CRC_RESIDUE   16'hF0B8
// Timing.
`define VTRF_CLK_NS        4
`define VTRF_FIELD_OFF_NS  100000
`endif

// [verilog/vtrf_crc16.v]
// Bit-serial CRC-16 register, least significant bit first.
`timescale 1ns/1ns
`include "vtrf_defines.vh"
module vtrf_crc16 (
   // Clock and control
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        ce,
   input  wire        init,
   input  wire        en,
   // Data
   input  wire        din,
   output reg  [15:0] crc_q,
   output wire [15:0] crc_next
);
   wire fb = crc_q[0] ^ din;
   assign crc_next = {1'b0, crc_q[15:1]} ^ (fb ? `VTRF_CRC_POLY : 16'h0000);

   always @(posedge aclk) begin
      if (!aresetn) begin
         crc_q <= `VTRF_CRC_PRESET;
      end else if (ce) begin
         if (init) begin
            crc_q <= `VTRF_CRC_PRESET;
         end else if (en) begin
            crc_q <= crc_next;
         end
      end
   end
endmodule // vtrf_crc16

// [verilog/vtrf_request_filter.v]
// Tag-side request filter, state machine and responder with AXI4-Lite.
//
// Summary of operation
// - Transmit only after a complete, valid request was received and accepted.
// - Response holds flags, parameters, data, two-byte CRC, no command code.
// - Frames carry whole bytes; bit count must be a multiple of eight.
// - Bits go least significant first; multi-byte fields lowest byte first.
// - Optional fields exist exactly when their flag bit is one.
// - Four states: off, ready, quiet, selected; off without field energy.
// - Ready answers requests with select flag clear; with select flag set it answers only with the error reply, when address flag is set too.
// - Quiet answers everything except inventory requests with address flag and select requests without address flag.
// - Selected answers select, matching addressed and non-addressed requests.
// - Drop to off after field absent for the field-off timeout.
// - Address flag set: compare carried UID, execute and answer on match.
// - Addressed request with a different UID: stay silent; a Select sends a selected tag back to ready.
// - Address flag clear: no UID carried, every tag executes and answers.
// - Select flag set: no UID, only a selected tag executes and answers.
// - Discard frame silently when its CRC check fails.
// - CRC-16 preset all ones over all bytes between start and CRC.
// - Inventory flag chooses meaning of upper four flag bits.
`timescale 1ns/1ns
`include "vtrf_defines.vh"
module vtrf_request_filter #(
   parameter        FIELD_OFF_CYCLES =
      (`VTRF_FIELD_OFF_NS + `VTRF_CLK_NS - 1) / `VTRF_CLK_NS,
   // Arbitrary identifier value; set per instance.
   parameter [63:0] TAG_UID = 64'h0123_4567_89AB_CDEF
) (
   // Clock, reset, enable
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        ce,
   // AXI4-Lite write
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // RF front end
   input  wire        field_on,
   input  wire        link_clk,
   input  wire        rx_data,
   input  wire        rx_frame,
   output reg         tx_data,
   output reg         tx_frame
);
   // Synchronisers: link clock, data, frame, field.
   reg  [3:0] s1_q, s2_q, s3_q;
   always @(posedge aclk) begin
      if (!aresetn) begin
         s1_q <= 4'h0;
         s2_q <= 4'h0;
         s3_q <= 4'h0;
      end else if (ce) begin
         s1_q <= {field_on, rx_frame, rx_data, link_clk};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   wire tick_r   = s2_q[0] & ~s3_q[0];
   wire tick_f   = ~s2_q[0] & s3_q[0];
   wire rbit     = s2_q[1];
   wire frm_rise = s2_q[2] & ~s3_q[2];
   wire frm_fall = ~s2_q[2] & s3_q[2];
   wire field    = s2_q[3];

   reg  [1:0]  state_q;
   reg         enable_q;
   reg         tx_busy_q;
   reg  [31:0] off_cnt_q;
   reg  [31:0] txd_q;
   reg  [2:0]  txlen_q;

   // Receive path; bytes assemble least significant bit first.
   reg  [7:0]  rsh_q, flags_q, cmd_q, nbytes_q, drop_q;
   reg  [2:0]  rbits_q;
   reg  [63:0] uid_rx_q;
   reg         rx_act_q;
   wire [7:0]  rbyte = {rbit, rsh_q[7:1]};
   wire [15:0] rcrc_q;
   wire        rx_take = ce & rx_act_q & tick_r;

   vtrf_crc16 u_rx_crc (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .ce       (ce),
      .init     (frm_rise),
      .en       (rx_take),
      .din      (rbit),
      .crc_q    (rcrc_q),
      .crc_next ()
   );

   always @(posedge aclk) begin
      if (!aresetn) begin
         rx_act_q <= 1'b0;
         rsh_q    <= 8'h00;
         rbits_q  <= 3'h0;
         nbytes_q <= 8'h00;
         flags_q  <= 8'h00;
         cmd_q    <= 8'h00;
         uid_rx_q <= 64'h0;
      end else if (ce) begin
         if (frm_rise) begin
            rx_act_q <= 1'b1;
            rbits_q  <= 3'h0;
            nbytes_q <= 8'h00;
         end else if (frm_fall) begin
            rx_act_q <= 1'b0;
         end else if (rx_take) begin
            rsh_q   <= rbyte;
            rbits_q <= rbits_q + 3'h1;
            if (rbits_q == 3'h7) begin
               if (nbytes_q != 8'hFF)
                  nbytes_q <= nbytes_q + 8'h01;
               if (nbytes_q == 8'h00)
                  flags_q <= rbyte;
               if (nbytes_q == 8'h01)
                  cmd_q <= rbyte;
               // UID arrives lowest byte first, so shift in from the top.
               if (nbytes_q >= `VTRF_UID_FIRST &&
                   nbytes_q <= `VTRF_UID_LAST)
                  uid_rx_q <= {rbyte, uid_rx_q[63:8]};
            end
         end
      end
   end

   // Frame acceptance and addressing decision.
   wire inv = flags_q[`VTRF_F_INV];
   wire sel = flags_q[`VTRF_F_SEL];
   wire adr = flags_q[`VTRF_F_ADR];
   wire uid_ok = (uid_rx_q == TAG_UID) &&
                 (nbytes_q >= `VTRF_MIN_ADDR_BYTES);
   wire crc_ok = (rcrc_q == `VTRF_CRC_RESIDUE);
   wire frame_ok = frm_fall & enable_q & ~tx_busy_q &
                   (state_q != `VTRF_S_OFF) &
                   (rbits_q == 3'h0) &
                   (nbytes_q >= `VTRF_MIN_BYTES) &
                   crc_ok;
   wire frame_bad = frm_fall & enable_q & (state_q != `VTRF_S_OFF) &
                    ~frame_ok;

   reg       exec, err, respond;
   reg [1:0] nxt_st;
   always @* begin
      exec   = 1'b0;
      err    = 1'b0;
      nxt_st = state_q;
      if (inv) begin
         // Upper flags hold inventory parameters here.          
         exec = !(state_q == `VTRF_S_QUIET && adr);
      end else if (sel && adr) begin
         err = 1'b1;
      end else if (sel) begin
         exec = (state_q == `VTRF_S_SEL);
      end else if (adr) begin
         exec = uid_ok;
         // Another tag being selected pushes this one back to ready.
         if (!uid_ok && state_q == `VTRF_S_SEL &&
             cmd_q == `VTRF_CMD_SELECT)
            nxt_st = `VTRF_S_READY;
      end else begin
         exec = 1'b1;
      end
      if (exec) begin
         case (cmd_q)
            `VTRF_CMD_QUIET:  if (adr) nxt_st = `VTRF_S_QUIET;
            `VTRF_CMD_SELECT: if (adr) nxt_st = `VTRF_S_SEL;
            `VTRF_CMD_RESET:  nxt_st = `VTRF_S_READY;
            default:          nxt_st = state_q;
         endcase
      end
      // Stay-quiet answers only with the error reply, when select and address flags are both set.
      respond = (exec && cmd_q != `VTRF_CMD_QUIET) || err;
   end
   wire start_tx = frame_ok & respond;

   // Tag state, field supervision and field-off timer.
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_q   <= `VTRF_S_OFF;
         off_cnt_q <= 32'h0;
      end else if (ce) begin
         if (field) begin
            off_cnt_q <= 32'h0;
            if (state_q == `VTRF_S_OFF)
               state_q <= `VTRF_S_READY;
            else if (frame_ok)
               state_q <= nxt_st;
         end else if (off_cnt_q >= FIELD_OFF_CYCLES - 1) begin
            state_q <= `VTRF_S_OFF;
         end else begin
            off_cnt_q <= off_cnt_q + 32'h1;
         end
      end
   end

   // Transmit path: flags, error code or data bytes, then inverted CRC.
   reg  [7:0]  tsh_q, crc_hi_q, nbyte;
   reg  [2:0]  tbits_q, tidx_q, tlen_q;
   reg         terr_q, tend_q;
   wire [15:0] tcrc_nx;
   wire        tx_shift = ce & tx_busy_q & tick_f & ~tend_q;
   wire [2:0]  body_last = terr_q ? 3'h1 : tlen_q;
   wire [2:0]  nidx = tidx_q + 3'h1;

   vtrf_crc16 u_tx_crc (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .ce       (ce),
      .init     (start_tx),
      .en       (tx_shift),
      .din      (tsh_q[0]),
      .crc_q    (),
      .crc_next (tcrc_nx)
   );

   always @* begin
      nbyte = crc_hi_q;
      if (nidx <= body_last) begin
         if (terr_q)
            nbyte = `VTRF_ERR_CODE;
         else
            case (nidx)
               3'h1:    nbyte = txd_q[7:0];
               3'h2:    nbyte = txd_q[15:8];
               3'h3:    nbyte = txd_q[23:16];
               default: nbyte = txd_q[31:24];
            endcase
      end else if (nidx == body_last + 3'h1) begin
         nbyte = ~tcrc_nx[7:0];
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         tx_busy_q <= 1'b0;
         tx_frame  <= 1'b0;
         tx_data   <= 1'b0;
         tsh_q     <= 8'h00;
         tbits_q   <= 3'h0;
         tidx_q    <= 3'h0;
         tlen_q    <= 3'h0;
         terr_q    <= 1'b0;
         tend_q    <= 1'b0;
         crc_hi_q  <= 8'h00;
      end else if (ce) begin
         if (state_q == `VTRF_S_OFF) begin
            tx_busy_q <= 1'b0;
            tx_frame  <= 1'b0;
         end else if (start_tx) begin
            tx_busy_q <= 1'b1;
            terr_q    <= err;
            tlen_q    <= txlen_q;
            tidx_q    <= 3'h0;
            tbits_q   <= 3'h0;
            tend_q    <= 1'b0;
            tsh_q     <= err ? `VTRF_RSP_ERRFLAG : `VTRF_RSP_OK;
         end else if (tx_busy_q && tick_f) begin
            if (tend_q) begin
               tx_busy_q <= 1'b0;
               tx_frame  <= 1'b0;
            end else begin
               tx_frame <= 1'b1;
               tx_data  <= tsh_q[0];
               tsh_q    <= {1'b0, tsh_q[7:1]};
               tbits_q  <= tbits_q + 3'h1;
               if (tbits_q == 3'h7) begin
                  // Whole bytes only; the frame ends on a byte boundary.
                  if (tidx_q == body_last + 3'h2) begin
                     tend_q <= 1'b1;
                  end else begin
                     tidx_q <= nidx;
                     tsh_q  <= nbyte;
                     if (nidx == body_last + 3'h1)
                        crc_hi_q <= ~tcrc_nx[15:8];
                  end
               end
            end
         end
      end
   end

   // AXI4-Lite slave: address and data taken in either order.
   reg  [7:0]  awaddr_q;
   reg  [31:0] wdata_q;
   reg  [3:0]  wstrb_q;
   reg         aw_full_q, w_full_q, lr_new_q, lr_err_q;
   assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_full_q & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   wire wr_go = aw_full_q & w_full_q & ~s_axi_bvalid;
   wire wr_map = (awaddr_q[7:2] <= `VTRF_REG_TXLEN >> 2) &&
                 (awaddr_q[7:2] != `VTRF_REG_STATUS >> 2);
   wire lr_clr = wr_go && awaddr_q == `VTRF_REG_LASTREQ &&
                 wstrb_q[3] && wdata_q[`VTRF_LR_NEW_BIT];

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q    <= 1'b0;
         w_full_q     <= 1'b0;
         awaddr_q     <= 8'h00;
         wdata_q      <= 32'h0;
         wstrb_q      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
         enable_q     <= `VTRF_CTRL_RST;
         txd_q        <= `VTRF_TXDATA_RST;
         txlen_q      <= `VTRF_TXLEN_RST;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            awaddr_q  <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_full_q    <= 1'b0;
            w_full_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? 2'b00 : 2'b10;
            if (awaddr_q == `VTRF_REG_CTRL && wstrb_q[0])
               enable_q <= wdata_q[`VTRF_CTRL_EN_BIT];
            if (awaddr_q == `VTRF_REG_TXLEN && wstrb_q[0])
               txlen_q <= (wdata_q[2:0] > `VTRF_TXLEN_MAX) ?
                          `VTRF_TXLEN_MAX : wdata_q[2:0];
            if (awaddr_q == `VTRF_REG_TXDATA) begin
               if (wstrb_q[0]) txd_q[7:0]   <= wdata_q[7:0];
               if (wstrb_q[1]) txd_q[15:8]  <= wdata_q[15:8];
               if (wstrb_q[2]) txd_q[23:16] <= wdata_q[23:16];
               if (wstrb_q[3]) txd_q[31:24] <= wdata_q[31:24];
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Last accepted request and drop counter; a new request beats a clear.
   reg [7:0] lr_flags_q, lr_cmd_q, lr_bytes_q;
   always @(posedge aclk) begin
      if (!aresetn) begin
         lr_flags_q <= 8'h00;
         lr_cmd_q   <= 8'h00;
         lr_bytes_q <= 8'h00;
         lr_new_q   <= 1'b0;
         lr_err_q   <= 1'b0;
         drop_q     <= 8'h00;
      end else if (ce) begin
         if (frame_ok && (exec || err)) begin
            lr_flags_q <= flags_q;
            lr_cmd_q   <= cmd_q;
            lr_bytes_q <= nbytes_q;
            lr_err_q   <= err;
            lr_new_q   <= 1'b1;
         end else if (lr_clr) begin
            lr_new_q <= 1'b0;
         end
         if (frame_bad && drop_q != 8'hFF)
            drop_q <= drop_q + 8'h01;
      end
   end

   reg [31:0] rd;
   always @* begin
      rd = 32'h0;
      case ({s_axi_araddr[7:2], 2'b00})
         `VTRF_REG_CTRL:   rd[`VTRF_CTRL_EN_BIT] = enable_q;
         `VTRF_REG_STATUS: begin
            rd[`VTRF_ST_STATE_LSB +: 2] = state_q;
            rd[`VTRF_ST_BUSY_BIT]       = tx_busy_q;
            rd[`VTRF_ST_DROP_LSB +: 8]  = drop_q;
         end
         `VTRF_REG_LASTREQ: begin
            rd[`VTRF_LR_FLAGS_LSB +: 8] = lr_flags_q;
            rd[`VTRF_LR_CMD_LSB +: 8]   = lr_cmd_q;
            rd[`VTRF_LR_BYTES_LSB +: 8] = lr_bytes_q;
            rd[`VTRF_LR_NEW_BIT]        = lr_new_q;
            rd[`VTRF_LR_ERR_BIT]        = lr_err_q;
         end
         `VTRF_REG_TXDATA: rd = txd_q;
         `VTRF_REG_TXLEN:  rd[2:0] = txlen_q;
         default:          rd = 32'h0;
      endcase
   end
   wire rd_map = s_axi_araddr[7:2] <= `VTRF_REG_TXLEN >> 2;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= 2'b00;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd;
            s_axi_rresp  <= rd_map ? 2'b00 : 2'b10;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // vtrf_request_filter

// [tb/vtrf_properties.sv]
// Concurrent checks on the ports of the vicinity tag request filter.
`timescale 1ns/1ns
module vtrf_props (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite handshakes
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // RF front end
   input wire field_on,
   input wire link_clk,
   input wire rx_frame,
   input wire tx_data,
   input wire tx_frame
);
   logic [7:0] gap_q;
   logic [7:0] nbit_q;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Cycles since the reader frame ended, and link falls during a reply.
   always @(posedge aclk) begin
      if (!aresetn || rx_frame)
         gap_q <= 8'h00;
      else if (gap_q != 8'hFF)
         gap_q <= gap_q + 8'h01;
      if (!aresetn || !tx_frame)
         nbit_q <= 8'h00;
      else if ($fell(link_clk))
         nbit_q <= nbit_q + 8'h01;
   end

   AST_TX_AFTER_REQ: assert property (
      $rose(tx_frame) |-> field_on && gap_q > 8'h02 && gap_q < 8'h78)
      else $error("unrequested reply");
   AST_TX_WHOLE_BYTES: assert property (
      $fell(tx_frame) |-> nbit_q[2:0] == 3'h0 && nbit_q >= 8'h18)
      else $error("reply is not whole bytes");
   AST_TX_NO_FIELD: assert property (
      !field_on [*8] |-> !$rose(tx_frame))
      else $error("reply without field energy");
   AST_TX_BIT_ON_FALL: assert property (
      tx_frame && $changed(tx_data) |-> !link_clk)
      else $error("tx bit moved early");
   AST_B_LAT: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("bvalid latency");
   AST_B_ONE: assert property (
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   AST_AW_BLOCK: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken early");
   AST_R_LAT: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("rvalid latency");
   AST_R_ONE: assert property (
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
   AST_AR_READY: assert property (
      s_axi_arready == !s_axi_rvalid)
      else $error("read address ready wrong");
endmodule // vtrf_props

bind vtrf_request_filter vtrf_props u_vtrf_props (.*);

// [tb/vtrf_reader.sv]
// Reader model: frames requests onto the link and collects replies.
`timescale 1ns/1ns
module vtrf_reader (
   // Link towards the tag
   output logic link_clk,
   output logic rx_data,
   output logic rx_frame,
   // Reply from the tag
   input  wire  tx_data,
   input  wire  tx_frame
);
   logic [7:0] rsp[$];
   logic [7:0] acc;
   int         nb;

   initial begin
      link_clk = 1'b0;
      rx_data  = 1'b1;
      rx_frame = 1'b0;
   end

   function automatic logic [15:0] crc16(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (b[i])
         for (int k = 0; k < 8; k++)
            c = (c[0] ^ b[i][k]) ? (c >> 1) ^ 16'h8408 : c >> 1;
      return c;
   endfunction

   // One link period; the clock rests low so it stands still between frames.
   task automatic tick(input logic b);
      rx_data = b;
      #40 link_clk = 1'b1;
      if (tx_frame) begin
         acc = {tx_data, acc[7:1]};
         nb++;
         if (nb % 8 == 0)
            rsp.push_back(acc);
      end
      #80 link_clk = 1'b0;
      #40;
   endtask

   // Mode 1 spoils the check word, mode 2 adds a stray bit.
   task automatic send(input logic [7:0] b[$], input int md);
      logic [15:0] c;
      c = ~crc16(b);
      b.push_back(c[7:0] ^ {7'h00, md == 1});
      b.push_back(c[15:8]);
      rsp.delete();
      nb = 0;
      #1 rx_frame = 1'b1;
      foreach (b[i])
         for (int k = 0; k < 8; k++)
            tick(b[i][k]);
      if (md == 2)
         tick(1'b1);
      rx_frame = 1'b0;
      // Released data line toggles so a stale level is never mistaken.
      for (int i = 0; i < 70 && (i < 4 || tx_frame); i++)
         tick(~rx_data);
   endtask
endmodule // vtrf_reader

// [tb/tb_top.sv]
// Self-checking bench for the vicinity tag request filter.
`timescale 1ns/1ns
`include "vtrf_defines.vh"
module tb_top;
   // Arbitrary identifier, handed to the design as well.
   localparam logic [63:0] UID  = 64'h1122_3344_5566_7788;
   localparam logic [7:0]  FSEL = 8'h01 << `VTRF_F_SEL;
   localparam logic [7:0]  FADR = 8'h01 << `VTRF_F_ADR;
   localparam logic [7:0]  FINV = 8'h01 << `VTRF_F_INV;
   localparam logic [7:0]  CGEN = 8'h20;
   logic        aclk          = 1'b0;
   logic        aresetn       = 1'b0;
   logic        field_on      = 1'b0;
   logic [7:0]  s_axi_awaddr  = 8'h00;
   logic        s_axi_awvalid = 1'b0;
   logic [31:0] s_axi_wdata   = 32'h0000_0000;
   logic        s_axi_wvalid  = 1'b0;
   logic        s_axi_bready  = 1'b0;
   logic [7:0]  s_axi_araddr  = 8'h00;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready  = 1'b0;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire         s_axi_rvalid, link_clk, rx_data, rx_frame, tx_data, tx_frame;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   int          n_errors = 0;
   int          n_checks = 0;
   logic [31:0] txd;
   logic [2:0]  txl;

   always #2 aclk = ~aclk;

   vtrf_request_filter #(.FIELD_OFF_CYCLES(50), .TAG_UID(UID))
   u_vtrf_request_filter (.ce(1'b1), .s_axi_wstrb(4'hF), .*);

   vtrf_reader u_vtrf_reader (.*);

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic hang;
      n_errors++;
      $display("MISMATCH t=%0t wait limit", $time);
      give_verdict();
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] er);
      logic aw;
      logic w;
      int   n;
      @(posedge aclk);
      aw = 1'b0;
      w = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50 && !(aw && w); n++) begin
         @(posedge aclk);
         aw = aw | s_axi_awready;
         w = w | s_axi_wready;
         s_axi_awvalid <= !aw;
         s_axi_wvalid <= !w;
      end
      n = 0;
      do @(posedge aclk); while (!s_axi_bvalid && ++n < 50);
      s_axi_bready <= 1'b0;
      if (n >= 50)
         hang();
      check(s_axi_bresp, er);
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      do @(posedge aclk); while (!s_axi_arready && ++n < 50);
      s_axi_arvalid <= 1'b0;
      n = 0;
      while (!s_axi_rvalid && n < 50) begin
         @(posedge aclk);
         n++;
      end
      s_axi_rready <= 1'b0;
      if (n >= 50)
         hang();
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask

   task automatic st(input logic [1:0] s);
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(`VTRF_REG_STATUS, d, r);
      check(d[1:0], s);
   endtask

   // Expected reply: 0 silent, 1 data bytes, 2 error code.
   task automatic xfer(input logic [7:0] f, input logic [7:0] c,
                       input logic [63:0] u, input int md, input int kd);
      logic [7:0]  b[$];
      logic [7:0]  e[$];
      logic [15:0] k;
      b = {f, c};
      if ((f & FADR) != 8'h00)
         for (int i = 0; i < 8; i++)
            b.push_back(u[8*i +: 8]);
      if (kd == 2)
         e = {8'h01, `VTRF_ERR_CODE};
      if (kd == 1)
         e = {8'h00};
      for (int i = 0; kd == 1 && i < txl; i++)
         e.push_back(txd[8*i +: 8]);
      k = ~u_vtrf_reader.crc16(e);
      if (kd != 0)
         e = {e, k[7:0], k[15:8]};
      @(posedge aclk);
      u_vtrf_reader.send(b, md);
      check(u_vtrf_reader.rsp.size(), e.size());
      foreach (e[i])
         check(u_vtrf_reader.rsp[i], e[i]);
   endtask

   task automatic t_regs;
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(`VTRF_REG_CTRL, d, r);
      check(d, 32'h0000_0001);
      axi_rd(8'h14, d, r);
      check(r, 2'b10);
      axi_wr(`VTRF_REG_STATUS, 32'hFFFF_FFFF, 2'b10);
      axi_wr(`VTRF_REG_TXLEN, 32'h0000_0007, 2'b00);
      axi_rd(`VTRF_REG_TXLEN, d, r);
      check(d, 32'h0000_0004);
      txd = 32'hA55A_3CC3;
      txl = 3'h2;
      axi_wr(`VTRF_REG_TXDATA, txd, 2'b00);
      axi_wr(`VTRF_REG_TXLEN, 32'h0000_0002, 2'b00);
      st(`VTRF_S_OFF);
      xfer(8'h02, CGEN, UID, 0, 0);
      $display("t_regs done");
   endtask

   task automatic t_ready;
      logic [31:0] d;
      logic [31:0] q;
      logic [1:0]  r;
      field_on <= 1'b1;
      repeat (10) @(posedge aclk);
      st(`VTRF_S_READY);
      xfer(8'h02, CGEN, UID, 0, 1);
      axi_rd(`VTRF_REG_LASTREQ, q, r);
      check(q[23:0], {8'h04, CGEN, 8'h02});
      xfer(8'h02 | FSEL, CGEN, UID, 0, 0);
      axi_rd(`VTRF_REG_STATUS, d, r);
      xfer(8'h02, CGEN, UID, 1, 0);
      xfer(8'h02, CGEN, UID, 2, 0);
      axi_rd(`VTRF_REG_STATUS, q, r);
      check(q[15:8] - d[15:8], 8'h02);
      $display("t_ready done");
   endtask

   task automatic t_addr;
      logic [31:0] d;
      logic [1:0]  r;
      xfer(FADR, `VTRF_CMD_SELECT, ~UID, 0, 0);
      st(`VTRF_S_READY);
      xfer(FADR, `VTRF_CMD_SELECT, UID, 0, 1);
      st(`VTRF_S_SEL);
      xfer(FSEL, CGEN, UID, 0, 1);
      xfer(8'h02, CGEN, UID, 0, 1);
      xfer(FSEL | FADR, CGEN, UID, 0, 2);
      axi_rd(`VTRF_REG_LASTREQ, d, r);
      check(d[25:24], 2'b11);
      axi_wr(`VTRF_REG_LASTREQ, 32'h0100_0000, 2'b00);
      axi_rd(`VTRF_REG_LASTREQ, d, r);
      check(d[24], 1'b0);
      $display("t_addr done");
   endtask

   task automatic t_quiet;
      xfer(FADR, `VTRF_CMD_QUIET, UID, 0, 0);
      st(`VTRF_S_QUIET);
      xfer(8'h02, CGEN, UID, 0, 1);
      xfer(FINV | FADR, 8'h01, UID, 0, 0);
      xfer(FINV, 8'h01, UID, 0, 1);
      xfer(FSEL, CGEN, UID, 0, 0);
      xfer(FADR, `VTRF_CMD_RESET, UID, 0, 1);
      st(`VTRF_S_READY);
      $display("t_quiet done");
   endtask

   task automatic t_off;
      xfer(FADR, `VTRF_CMD_SELECT, UID, 0, 1);
      field_on <= 1'b0;
      repeat (30) @(posedge aclk);
      field_on <= 1'b1;
      repeat (10) @(posedge aclk);
      st(`VTRF_S_SEL);
      field_on <= 1'b0;
      repeat (80) @(posedge aclk);
      st(`VTRF_S_OFF);
      xfer(8'h02, CGEN, UID, 0, 0);
      field_on <= 1'b1;
      repeat (10) @(posedge aclk);
      st(`VTRF_S_READY);
      $display("t_off done");
   endtask

   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_ready();
      t_addr();
      t_quiet();
      t_off();
      give_verdict();
   end
endmodule // tb_top
